//--- logic/sdwps_pkg.sv
// Shared constants for the write, precharge and self refresh sequencer
package sdwps_pkg;
   localparam int          BANKS          = 8;
   localparam int          BANK_W         = 3;
   localparam logic [1:0]  BURST_FIXED8   = 2'h0;
   localparam logic [1:0]  BURST_OTF      = 2'h1;
   localparam logic [1:0]  BURST_FIXED4   = 2'h2;
   localparam int          BEATS_CHOP     = 4;
   localparam int          BEATS_FULL     = 8;
   localparam int          CNT_W          = 8;
   localparam logic [7:0]  WL_RESET       = 8'h05;
   localparam int          TCKE_NS        = 5;
   localparam int          CLK_NS         = 25;
   localparam int          TCKE_CYC       = (TCKE_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [3:0]  CMD_NOP        = 4'h7;
   localparam logic [3:0]  CMD_ACT        = 4'h3;
   localparam logic [3:0]  CMD_RD         = 4'h5;
   localparam logic [3:0]  CMD_WR         = 4'h4;
   localparam logic [3:0]  CMD_PRE        = 4'h2;
   localparam logic [3:0]  CMD_REF        = 4'h1;
   localparam logic [1:0]  BANKS_IDLE_RST = 2'h0;
   typedef enum logic [1:0] {
      SD_IDLE   = 2'b00,
      SD_WRITE  = 2'b01,
      SD_SELF   = 2'b10
   } sdwps_state_type;
endpackage : sdwps_pkg

//--- logic/sdwps_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module sdwps_sync #(
   parameter int W = 1
) (
   input  wire logic         ref_clk,
   input  wire logic         nrst,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] stage1_ff;
   logic [W-1:0] nxt_stage1;
   logic [W-1:0] stage2_ff;
   logic [W-1:0] nxt_stage2;

   if (W < 1) begin : g_bad_width
      $error("sdwps_sync: width below one");
   end

   always_comb begin
      nxt_stage1 = din;
      nxt_stage2 = stage1_ff;
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         stage1_ff <= '0;
         stage2_ff <= '0;
      end else begin
         stage1_ff <= nxt_stage1;
         stage2_ff <= nxt_stage2;
      end
   end

   assign dout = stage2_ff;
endmodule : sdwps_sync

//--- logic/sdwps_core.sv
// Command sequencer: writes with chop/mask, precharge, self refresh
// Behaviour
// - Mode 10 forces four-beat chop always
// - Mode 01: chop bit low chops, high full
// - Precharge: all-bit closes all, else one bank
// - Refresh with clock enable low enters self refresh
// - Loop disabled in self refresh, reset on exit
// - Self refresh ignores all but enable, reset
// - One internal refresh within tCKE on entry
// - Exit intervals start at first enable-high edge
// - Write latency is additive plus write latency
// - Masked write beats are not stored
`timescale 1ns/10ps
module sdwps_core
   import sdwps_pkg::*;
#(
   parameter int DQ_W  = 8,
   parameter int COL_W = 10
) (
   input  wire logic                      ref_clk,
   input  wire logic                      nrst,
   input  wire logic                      linkClk,
   input  wire logic                      clkEnable,
   input  wire logic [3:0]                cmdCode,
   input  wire logic [sdwps_pkg::BANK_W-1:0] bankSel,
   input  wire logic                      prechargeAllSelectBit,
   input  wire logic                      burstChopSelectAddressBit,
   input  wire logic [COL_W-1:0]          colAddr,
   input  wire logic [1:0]                modeRegisterZeroBurst,
   input  wire logic [7:0]                writeLatency,
   input  wire logic                      writeStrobe,
   input  wire logic [DQ_W-1:0]           dataIn,
   input  wire logic                      dataMaskInput,
   output logic      [sdwps_pkg::BANKS-1:0] bankOpen,
   output logic                           selfRefresh,
   output logic                           delayLoopEnable,
   output logic                           delayLoopReset,
   output logic                           refreshPulse,
   output logic                           storeValid,
   output logic      [COL_W-1:0]          storeCol,
   output logic      [DQ_W-1:0]           storeData,
   output logic                           writeActive,
   output logic                           burstChop
);
   import sdwps_pkg::*;

   // Column offsets need three bits to address an eight-beat burst
   if (DQ_W < 1 || COL_W < 3) begin : g_bad_width
      $error("sdwps_core: bad widths");
   end

   // Every pin but the burst mode and write latency settings crosses two flops; the link clock is sampled like data
   localparam int PW = 10 + BANK_W + COL_W + DQ_W;
   logic [PW-1:0] pinRaw;
   logic [PW-1:0] pinSync;
   assign pinRaw = {linkClk, clkEnable, cmdCode, bankSel, prechargeAllSelectBit,
                    burstChopSelectAddressBit, colAddr, writeStrobe, dataIn, dataMaskInput};
   sdwps_sync #(.W(PW)) uSync (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .din     (pinRaw),
      .dout    (pinSync)
   );

   logic                sLinkClk;
   logic                sCke;
   logic [3:0]          sCmd;
   logic [BANK_W-1:0]   sBank;
   logic                sAll;
   logic                sChopBit;
   logic [COL_W-1:0]    sCol;
   logic                sStrobe;
   logic [DQ_W-1:0]     sData;
   logic                sMask;
   assign {sLinkClk, sCke, sCmd, sBank, sAll, sChopBit, sCol, sStrobe, sData, sMask} =
          pinSync;

   sdwps_state_type     state_ff, nxt_state;
   logic                linkPrev_ff, nxt_linkPrev;
   logic                strobePrev_ff, nxt_strobePrev;
   logic [BANKS-1:0]    bankOpen_ff, nxt_bankOpen;
   logic [CNT_W-1:0]    latCnt_ff, nxt_latCnt;
   logic [3:0]          beatCnt_ff, nxt_beatCnt;
   logic [3:0]          beatsTotal_ff, nxt_beatsTotal;
   logic                chop_ff, nxt_chop;
   logic [COL_W-1:0]    col_ff, nxt_col;
   logic                dllOn_ff, nxt_dllOn;
   logic                dllRst_ff, nxt_dllRst;
   logic                refPulse_ff, nxt_refPulse;
   logic                storeValid_ff, nxt_storeValid;
   logic [DQ_W-1:0]     storeData_ff, nxt_storeData;
   logic [COL_W-1:0]    storeCol_ff, nxt_storeCol;

   logic linkRise;
   logic strobeRise;
   logic chopNow;
   assign linkRise   = sLinkClk & ~linkPrev_ff;
   assign strobeRise = sStrobe & ~strobePrev_ff;

   always_comb begin
      // Fixed chop wins over the per-command bit
      case (modeRegisterZeroBurst)
         BURST_FIXED4: chopNow = 1'b1;
         BURST_OTF:    chopNow = ~sChopBit;
         default:      chopNow = 1'b0;
      endcase
   end

   always_comb begin
      nxt_state      = state_ff;
      nxt_linkPrev   = sLinkClk;
      nxt_strobePrev = sStrobe;
      nxt_bankOpen   = bankOpen_ff;
      nxt_latCnt     = latCnt_ff;
      nxt_beatCnt    = beatCnt_ff;
      nxt_beatsTotal = beatsTotal_ff;
      nxt_chop       = chop_ff;
      nxt_col        = col_ff;
      nxt_dllOn      = dllOn_ff;
      nxt_dllRst     = 1'b0;
      nxt_refPulse   = 1'b0;
      nxt_storeValid = 1'b0;
      nxt_storeData  = storeData_ff;
      nxt_storeCol   = storeCol_ff;
      case (state_ff)
         SD_IDLE: begin
            if (linkRise) begin
               if (sCmd == CMD_REF && !sCke) begin
                  nxt_state    = SD_SELF;
                  nxt_dllOn    = 1'b0;
                  nxt_refPulse = 1'b1;
               end else if (sCmd == CMD_ACT) begin
                  nxt_bankOpen[sBank] = 1'b1;
               end else if (sCmd == CMD_PRE) begin
                  if (sAll) begin
                     nxt_bankOpen = '0;
                  end else begin
                     nxt_bankOpen[sBank] = 1'b0;
                  end
               end else if (sCmd == CMD_WR) begin
                  nxt_state      = SD_WRITE;
                  nxt_latCnt     = writeLatency;
                  nxt_beatCnt    = '0;
                  nxt_chop       = chopNow;
                  nxt_beatsTotal = chopNow ? 4'(BEATS_CHOP) : 4'(BEATS_FULL);
                  nxt_col        = sCol;
               end
            end
         end
         SD_WRITE: begin
            // Latency counts clock edges; beats then follow strobe edges. Only the
            // preamble falls in the last latency clock, so a rise there is beat 0
            if (latCnt_ff != '0 && !(latCnt_ff == CNT_W'(1) && strobeRise)) begin
               if (linkRise) begin
                  nxt_latCnt = latCnt_ff - CNT_W'(1);
               end
            end else if (strobeRise || (!sStrobe && strobePrev_ff)) begin
               nxt_latCnt = '0;
               // Preamble and postamble carry no data; only counted edges store
               if (!sMask) begin
                  nxt_storeValid = 1'b1;
                  nxt_storeData  = sData;
                  nxt_storeCol   = col_ff + COL_W'(beatCnt_ff);
               end
               nxt_beatCnt = beatCnt_ff + 4'h1;
               if (beatCnt_ff + 4'h1 == beatsTotal_ff) begin
                  nxt_state = SD_IDLE;
               end
            end
         end
         SD_SELF: begin
            // Only the enable matters here; commands are ignored
            if (sCke && linkRise) begin
               nxt_state  = SD_IDLE;
               nxt_dllOn  = 1'b1;
               nxt_dllRst = 1'b1;
            end
         end
         default: nxt_state = SD_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state_ff      <= SD_IDLE;
         linkPrev_ff   <= 1'b0;
         strobePrev_ff <= 1'b0;
         bankOpen_ff   <= '0;
         latCnt_ff     <= '0;
         beatCnt_ff    <= '0;
         beatsTotal_ff <= '0;
         chop_ff       <= 1'b0;
         col_ff        <= '0;
         dllOn_ff      <= 1'b1;
         dllRst_ff     <= 1'b0;
         refPulse_ff   <= 1'b0;
         storeValid_ff <= 1'b0;
         storeData_ff  <= '0;
         storeCol_ff   <= '0;
      end else begin
         state_ff      <= nxt_state;
         linkPrev_ff   <= nxt_linkPrev;
         strobePrev_ff <= nxt_strobePrev;
         bankOpen_ff   <= nxt_bankOpen;
         latCnt_ff     <= nxt_latCnt;
         beatCnt_ff    <= nxt_beatCnt;
         beatsTotal_ff <= nxt_beatsTotal;
         chop_ff       <= nxt_chop;
         col_ff        <= nxt_col;
         dllOn_ff      <= nxt_dllOn;
         dllRst_ff     <= nxt_dllRst;
         refPulse_ff   <= nxt_refPulse;
         storeValid_ff <= nxt_storeValid;
         storeData_ff  <= nxt_storeData;
         storeCol_ff   <= nxt_storeCol;
      end
   end

   assign bankOpen        = bankOpen_ff;
   assign selfRefresh     = (state_ff == SD_SELF);
   assign delayLoopEnable = dllOn_ff;
   assign delayLoopReset  = dllRst_ff;
   assign refreshPulse    = refPulse_ff;
   assign storeValid      = storeValid_ff;
   assign storeData       = storeData_ff;
   assign storeCol        = storeCol_ff;
   assign writeActive     = (state_ff == SD_WRITE);
   assign burstChop       = chop_ff;
endmodule : sdwps_core

//--- test/sdwps_core_assertions.sv
// Port-level checks for the write, precharge and self refresh sequencer
`timescale 1ns/10ps
module sdwps_core_chk
   import sdwps_pkg::*;
(
   input wire logic                        ref_clk,
   input wire logic                        nrst,
   input wire logic                        clkEnable,
   input wire logic                        burstChopSelectAddressBit,
   input wire logic [3:0]                  cmdCode,
   input wire logic [1:0]                  modeRegisterZeroBurst,
   input wire logic [sdwps_pkg::BANKS-1:0] bankOpen,
   input wire logic                        selfRefresh,
   input wire logic                        delayLoopEnable,
   input wire logic                        delayLoopReset,
   input wire logic                        refreshPulse,
   input wire logic                        writeActive,
   input wire logic                        burstChop
);
   import sdwps_pkg::*;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   // Pins pass two flops and an edge detector, so causes are looked up two cycles back
   loop_off_a: assert property (selfRefresh |-> !delayLoopEnable)
      else $error("delay loop on in self refresh");
   loop_reset_a: assert property ($fell(selfRefresh) |-> ##[0:2] delayLoopReset)
      else $error("no delay loop reset on exit");
   sr_entry_a: assert property ($rose(selfRefresh) |->
      $past(cmdCode, 2) == CMD_REF && !$past(clkEnable, 2))
      else $error("self refresh without entry command");
   sr_pulse_a: assert property ($rose(selfRefresh) |-> ##[0:1] refreshPulse)
      else $error("no internal refresh on entry");
   sr_exit_a: assert property ($fell(selfRefresh) |-> $past(clkEnable, 2))
      else $error("exit without clock enable");
   sr_freeze_a: assert property (selfRefresh && $past(selfRefresh) |-> $stable(bankOpen))
      else $error("banks changed in self refresh");
   bank_close_a: assert property (|($past(bankOpen) & ~bankOpen) |->
      $past(cmdCode, 2) == CMD_PRE)
      else $error("bank closed without precharge");
   fixed_chop_a: assert property ($rose(writeActive) &&
      modeRegisterZeroBurst == BURST_FIXED4 |-> burstChop)
      else $error("fixed chop mode not chopped");
   otf_chop_a: assert property ($rose(writeActive) && modeRegisterZeroBurst == BURST_OTF
      |-> burstChop != $past(burstChopSelectAddressBit, 2))
      else $error("per-command chop wrong");
   cover property ($rose(selfRefresh));
   cover property ($fell(selfRefresh));
   cover property ($fell(writeActive) && burstChop);
endmodule : sdwps_core_chk
bind sdwps_core sdwps_core_chk chk (.ref_clk(ref_clk), .nrst(nrst), .clkEnable(clkEnable),
   .burstChopSelectAddressBit(burstChopSelectAddressBit), .cmdCode(cmdCode),
   .modeRegisterZeroBurst(modeRegisterZeroBurst), .bankOpen(bankOpen),
   .selfRefresh(selfRefresh), .delayLoopEnable(delayLoopEnable),
   .delayLoopReset(delayLoopReset), .refreshPulse(refreshPulse),
   .writeActive(writeActive), .burstChop(burstChop));

//--- test/sdwps_ctrl_model.sv
// Memory controller model: link clock, commands, write strobe and data
`timescale 1ns/10ps
module sdwps_ctrl_model
   import sdwps_pkg::*;
#(
   parameter int WL  = 2,
   parameter int TWR = 4
) (
   output logic       linkClk,
   output logic       clkEnable,
   output logic [3:0] cmdCode,
   output logic [2:0] bankSel,
   output logic       prechargeAllSelectBit,
   output logic       burstChopSelectAddressBit,
   output logic [9:0] colAddr,
   output logic       writeStrobe,
   output logic [7:0] dataIn,
   output logic       dataMaskInput
);
   import sdwps_pkg::*;
   initial begin
      {clkEnable, writeStrobe, linkClk} = 3'h6;
      cmdCode = CMD_NOP;
      {bankSel, prechargeAllSelectBit, burstChopSelectAddressBit, colAddr} = '0;
      {dataIn, dataMaskInput} = '0;
      #14.5;
      // Free running; edges sit a fixed 2 ns after a bench clock edge
      forever #100 linkClk = ~linkClk;
   end
   // Clock never stopped or retimed, reference never floats, termination held off,
   // and only NOPs follow an exit
   task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic a10,
                        input logic a12, input logic [9:0] col, input logic cke);
      @(negedge linkClk);
      cmdCode = c;
      {bankSel, prechargeAllSelectBit, burstChopSelectAddressBit, colAddr} = {b, a10, a12, col};
      clkEnable = cke; // Held until the next command
      @(posedge linkClk);
      @(negedge linkClk);
      cmdCode = CMD_NOP;
      {bankSel, prechargeAllSelectBit, burstChopSelectAddressBit, colAddr} = ~{b, a10, a12, col};
   endtask : issue
   task automatic wr(input logic [9:0] col, input logic a12, input int n, input logic [7:0] m,
                     input int early);
      issue(CMD_WR, 3'h2, 1'b0, a12, col, 1'b1);
      // Early 0 puts the strobe a quarter clock late, 50 puts beat 0 on the clock edge
      #(50 + 200 * (WL - 2) - early);
      writeStrobe = 1'b1;
      #200 writeStrobe = 1'b0;
      for (int i = 0; i < n; i++) begin
         #50 dataIn = 8'hA0 + 8'(i);
         dataMaskInput = m[i];
         #50 writeStrobe = ~writeStrobe;
      end
      #100 writeStrobe = 1'b1;
      {dataIn, dataMaskInput} = ~{dataIn, dataMaskInput};
      // Recovery is a fixed TWR + 2 clocks after the postamble, whatever the burst length
      repeat (TWR + 2) @(posedge linkClk);
   endtask : wr
endmodule : sdwps_ctrl_model

//--- test/tb.sv
// Self-checking bench for the command sequencer
`timescale 1ns/10ps
module tb;
   import sdwps_pkg::*;
   logic        ref_clk = 1'b0;
   logic        nrst = 1'b0;
   logic [1:0]  modeRegisterZeroBurst = BURST_FIXED8;
   logic [7:0]  writeLatency = 8'h02;
   logic        linkClk, clkEnable, prechargeAllSelectBit, burstChopSelectAddressBit;
   logic        writeStrobe, dataMaskInput, selfRefresh, delayLoopEnable, delayLoopReset;
   logic        refreshPulse, storeValid, writeActive, burstChop;
   logic [3:0]  cmdCode;
   logic [2:0]  bankSel;
   logic [9:0]  colAddr, storeCol;
   logic [7:0]  dataIn, storeData, bankOpen;
   int          miscompares = 0;
   int          num_checks = 0;
   int          refreshes = 0;
   int          dllResets = 0;
   logic [17:0] seen [$];
   sdwps_core uut (
      .ref_clk                   (ref_clk),
      .nrst                      (nrst),
      .linkClk                   (linkClk),
      .clkEnable                 (clkEnable),
      .cmdCode                   (cmdCode),
      .bankSel                   (bankSel),
      .prechargeAllSelectBit     (prechargeAllSelectBit),
      .burstChopSelectAddressBit (burstChopSelectAddressBit),
      .colAddr                   (colAddr),
      .modeRegisterZeroBurst     (modeRegisterZeroBurst),
      .writeLatency              (writeLatency),
      .writeStrobe               (writeStrobe),
      .dataIn                    (dataIn),
      .dataMaskInput             (dataMaskInput),
      .bankOpen                  (bankOpen),
      .selfRefresh               (selfRefresh),
      .delayLoopEnable           (delayLoopEnable),
      .delayLoopReset            (delayLoopReset),
      .refreshPulse              (refreshPulse),
      .storeValid                (storeValid),
      .storeCol                  (storeCol),
      .storeData                 (storeData),
      .writeActive               (writeActive),
      .burstChop                 (burstChop)
   );
   sdwps_ctrl_model mdl (
      .linkClk                   (linkClk),
      .clkEnable                 (clkEnable),
      .cmdCode                   (cmdCode),
      .bankSel                   (bankSel),
      .prechargeAllSelectBit     (prechargeAllSelectBit),
      .burstChopSelectAddressBit (burstChopSelectAddressBit),
      .colAddr                   (colAddr),
      .writeStrobe               (writeStrobe),
      .dataIn                    (dataIn),
      .dataMaskInput             (dataMaskInput)
   );
   always #12.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      if (storeValid === 1'b1) seen.push_back({storeCol, storeData});
      if (refreshPulse === 1'b1) refreshes++;
      if (delayLoopReset === 1'b1) dllResets++;
   end
   task automatic check(input logic [17:0] got, input logic [17:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : stop_test
   task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic a10, input logic cke);
      mdl.issue(c, b, a10, 1'b0, 10'h000, cke);
      #50;
   endtask : cmd
   task automatic wtest(input logic [1:0] md, input logic a12, input int n, input logic [7:0] m,
                        input int early);
      int j;
      logic expChop;
      j = 0;
      expChop = (md == BURST_FIXED4) || (md == BURST_OTF && !a12);
      modeRegisterZeroBurst = md;
      seen.delete();
      mdl.wr(10'h3F8, a12, n, m, early);
      for (int i = 0; i < n; i++) begin
         if (!m[i]) begin
            if (j < seen.size()) check(seen[j], {10'h3F8 + 10'(i), 8'hA0 + 8'(i)});
            j++;
         end
      end
      check(18'(seen.size()), 18'(j));
      check(writeActive, 1'b0);
      check(burstChop, expChop);
      $display("write test mode %0d chop bit %0d done", md, a12);
   endtask : wtest
   initial begin
      #100000;
      miscompares++;
      stop_test();
   end
   initial begin
      repeat (6) @(posedge ref_clk);
      #2 nrst = 1'b1;
      cmd(CMD_ACT, 3'h3, 1'b0, 1'b1);
      cmd(CMD_ACT, 3'h2, 1'b0, 1'b1);
      check(bankOpen, 8'h0C);
      cmd(CMD_PRE, 3'h3, 1'b0, 1'b1);
      check(bankOpen, 8'h04);
      $display("bank test done");
      wtest(BURST_FIXED4, 1'b1, 4, 8'h00, 0);
      wtest(BURST_OTF, 1'b0, 4, 8'h02, 50);
      wtest(BURST_OTF, 1'b1, 8, 8'h81, 0);
      wtest(BURST_FIXED8, 1'b0, 8, 8'h00, 50);
      cmd(CMD_ACT, 3'h6, 1'b0, 1'b1);
      cmd(CMD_PRE, 3'h3, 1'b1, 1'b1); // All banks idle before entry
      check(bankOpen, 8'h00);
      cmd(CMD_REF, 3'h0, 1'b0, 1'b0);
      check({selfRefresh, delayLoopEnable}, 2'b10);
      check(18'(refreshes), 18'h00001);
      cmd(CMD_ACT, 3'h1, 1'b0, 1'b0);
      check({selfRefresh, bankOpen}, 9'h100);
      cmd(CMD_NOP, 3'h0, 1'b0, 1'b1);
      check({selfRefresh, delayLoopEnable}, 2'b01);
      check(18'(dllResets), 18'h00001);
      $display("self refresh test done");
      stop_test();
   end
endmodule : tb
